// file: hw/txc_top.sv
// Hardware configuration register, transmit buffer and transmit start control
`timescale 1ns/1ps
`include "txc_consts.svh"

// ----------------------------------------------------------------------------
// Transmit buffer
// ----------------------------------------------------------------------------
module txc_fifo #(
  parameter int WIDTH = `TXC_FIFO_WIDTH,
  parameter int DEPTH = `TXC_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready_out = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != '0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign count_out = count_q;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : txc_fifo

// ----------------------------------------------------------------------------
// Top
// ----------------------------------------------------------------------------
// How it works
// RQ1: Mode bit selects threshold table, unless buffering
// RQ2: Host sets mode one at 10M
// RQ3: Full-frame buffering waits for a complete frame
// RQ4: Mode and level ignored while buffering
// RQ5: Otherwise start early at chosen threshold
// RQ6: Empty buffer mid-frame reports transmit underrun
// RQ7: Allocation field in KB, resets to five
// RQ8: Status takes 512 bytes, data the rest
// RQ9: Host programs at least 2KB allocation
// RQ10: Command and payload words share data buffer
// RQ11: Receive side gets 16KB minus transmit
// RQ12: Level field sets start threshold in words
// RQ13: Reserved bits read zero, ignore writes
module txc_top (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  input wire logic tx_valid_in,
  input wire logic [31:0] tx_data_in,
  input wire logic tx_cmd_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  input wire logic mac_ready_in,
  output logic mac_valid_out,
  output logic [31:0] mac_data_out,
  output logic mac_cmd_out,
  output logic mac_last_out,
  output logic tx_underrun_out,
  output logic [14:0] tx_data_bytes_out,
  output logic [14:0] rx_bytes_out
);
  logic [31:0] cfg_q;
  txc_pkg::txc_state_t state_q;
  logic [5:0] frames_q;
  logic f_valid;
  logic f_ready;
  logic [33:0] f_data;
  logic [5:0] f_count;
  logic ffb;
  logic [3:0] alloc;
  logic [5:0] thr;
  logic go;
  logic pop_last;
  logic push_last;

  // --------------------------------------------------------------------------
  // Threshold lookup
  // --------------------------------------------------------------------------
  function automatic logic [5:0] thr_words(input logic mode, input logic [1:0] level);
    logic [5:0] w;
    w = '0;
    case ({mode, level})
      3'b100: w = `TXC_THR10_0;
      3'b101: w = `TXC_THR10_1;
      3'b110: w = `TXC_THR10_2;
      3'b111: w = `TXC_THR10_3;
      3'b000: w = `TXC_THR100_0;
      3'b001: w = `TXC_THR100_1;
      3'b010: w = `TXC_THR100_2;
      default: w = `TXC_THR100_3;
    endcase
    return w;
  endfunction : thr_words

  // --------------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q <= `TXC_CFG_RESET; // [RQ7]
    end else if (reg_wr_in && reg_addr_in == `TXC_CFG_OFFSET) begin
      cfg_q <= reg_wdata_in & `TXC_CFG_WMASK; // [RQ13]
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= (reg_addr_in == `TXC_CFG_OFFSET) ? cfg_q : 32'h0000_0000;
    end
  end

  assign ffb = cfg_q[`TXC_FFB_BIT];
  assign alloc = cfg_q[`TXC_ALLOC_HI:`TXC_ALLOC_LO];
  assign thr = thr_words(cfg_q[`TXC_TABLE_SEL_BIT], cfg_q[`TXC_LEVEL_HI:`TXC_LEVEL_LO]); // [RQ1] [RQ12]

  // --------------------------------------------------------------------------
  // Memory split
  // --------------------------------------------------------------------------
  // No floor on the allocation; a host that writes below 2KB gets what it asked
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_data_bytes_out <= `TXC_TX_DATA_RESET;
      rx_bytes_out <= `TXC_RX_RESET;
    end else begin
      tx_data_bytes_out <= {1'b0, alloc, 10'h000} - `TXC_TX_STATUS_BYTES; // [RQ8]
      rx_bytes_out <= `TXC_TOTAL_BYTES - {1'b0, alloc, 10'h000}; // [RQ11]
    end
  end

  // --------------------------------------------------------------------------
  // Buffer: payload and command words share it
  // --------------------------------------------------------------------------
  txc_fifo #(
    .WIDTH(`TXC_FIFO_WIDTH),
    .DEPTH(`TXC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(tx_valid_in),
    .in_data_in({tx_last_in, tx_cmd_in, tx_data_in}), // [RQ10]
    .in_ready_out(tx_ready_out),
    .out_valid_out(f_valid),
    .out_data_out(f_data),
    .out_ready_in(f_ready),
    .count_out(f_count)
  );

  assign f_ready = (state_q == txc_pkg::TXC_SEND && mac_ready_in) ||
                   (state_q == txc_pkg::TXC_DROP);
  assign pop_last = f_valid && f_ready && f_data[33];
  assign push_last = tx_valid_in && tx_ready_out && tx_last_in;

  // Complete frames held in the buffer
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frames_q <= '0;
    end else if (push_last && !pop_last) begin
      frames_q <= frames_q + 1'b1;
    end else if (pop_last && !push_last) begin
      frames_q <= frames_q - 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Transmit start and line sequencing
  // --------------------------------------------------------------------------
  // A frame shorter than the threshold still starts once its last word is in
  assign go = ffb ? (frames_q != '0) // [RQ3] [RQ4]
                 : (f_valid && (f_count >= thr || frames_q != '0)); // [RQ5]

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= txc_pkg::TXC_IDLE;
    end else begin
      case (state_q)
        txc_pkg::TXC_IDLE: begin
          if (go) begin
            state_q <= txc_pkg::TXC_SEND;
          end
        end
        txc_pkg::TXC_SEND: begin
          if (mac_ready_in && !f_valid) begin
            state_q <= txc_pkg::TXC_DROP; // [RQ6]
          end else if (pop_last) begin
            state_q <= txc_pkg::TXC_IDLE;
          end
        end
        txc_pkg::TXC_DROP: begin
          // Rest of an underrun frame is discarded up to its last word
          if (pop_last) begin
            state_q <= txc_pkg::TXC_IDLE;
          end
        end
        default: state_q <= txc_pkg::TXC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mac_valid_out <= 1'b0;
      mac_data_out <= '0;
      mac_cmd_out <= 1'b0;
      mac_last_out <= 1'b0;
    end else begin
      mac_valid_out <= state_q == txc_pkg::TXC_SEND && mac_ready_in && f_valid;
      if (state_q == txc_pkg::TXC_SEND && mac_ready_in && f_valid) begin
        mac_data_out <= f_data[31:0];
        mac_cmd_out <= f_data[32]; // [RQ10]
        mac_last_out <= f_data[33];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_underrun_out <= 1'b0;
    end else begin
      tx_underrun_out <= state_q == txc_pkg::TXC_SEND && mac_ready_in && !f_valid; // [RQ6]
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  cfg_reset_val_a: assert property ($rose(reset_n_in) |-> alloc == 4'h5) // [RQ7]
    else $error("allocation not five after reset");
  reserved_zero_a: assert property ((cfg_q & ~`TXC_CFG_WMASK) == 32'h0000_0000) // [RQ13]
    else $error("reserved bits not zero");
  alloc_write_a: assert property (reg_wr_in && reg_addr_in == `TXC_CFG_OFFSET |=> // [RQ7]
    alloc == $past(reg_wdata_in[19:16]))
    else $error("allocation write lost");
  ffb_waits_a: assert property (state_q == txc_pkg::TXC_IDLE && ffb && frames_q == '0 |=> // [RQ3]
    state_q != txc_pkg::TXC_SEND)
    else $error("started without whole frame");
  ffb_start_a: assert property (state_q == txc_pkg::TXC_IDLE && ffb && frames_q != '0 |=> // [RQ4]
    state_q == txc_pkg::TXC_SEND)
    else $error("whole frame not started");
  thr_start_a: assert property (state_q == txc_pkg::TXC_IDLE && !ffb && f_valid && // [RQ5]
    f_count >= thr |=> state_q == txc_pkg::TXC_SEND)
    else $error("threshold start missed");
  thr_hold_a: assert property (state_q == txc_pkg::TXC_IDLE && !ffb && f_count < thr && // [RQ1]
    frames_q == '0 |=> state_q == txc_pkg::TXC_IDLE)
    else $error("started below threshold");
  underrun_flag_a: assert property (state_q == txc_pkg::TXC_SEND && mac_ready_in && // [RQ6]
    !f_valid |=> tx_underrun_out ##1 !mac_valid_out)
    else $error("underrun not reported");
  split_sizes_a: assert property (##1 tx_data_bytes_out + `TXC_TX_STATUS_BYTES == // [RQ8]
    `TXC_TOTAL_BYTES - rx_bytes_out)
    else $error("memory split inconsistent");
  rx_size_a: assert property (##1 rx_bytes_out == // [RQ11]
    15'(`TXC_TOTAL_BYTES - {1'b0, $past(alloc), 10'h000}))
    else $error("receive share wrong");
  cmd_path_a: assert property (f_ready && f_valid && state_q == txc_pkg::TXC_SEND |=> // [RQ10]
    mac_valid_out && mac_cmd_out == $past(f_data[32]))
    else $error("command flag lost");

  ffb_frame_c: cover property (ffb && state_q == txc_pkg::TXC_SEND ##[1:64] mac_last_out);
  thr_frame_c: cover property (!ffb && state_q == txc_pkg::TXC_SEND && frames_q == '0);
  underrun_c: cover property (tx_underrun_out ##[1:64] state_q == txc_pkg::TXC_IDLE);
  full_c: cover property (!tx_ready_out);
endmodule : txc_top

// file: include/txc_consts.svh
// Constants for the transmit start and FIFO allocation configuration block
`ifndef TXC_CONSTS_SVH
`define TXC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TXC_CFG_OFFSET 8'h74
`define TXC_CFG_RESET 32'h0005_0000
`define TXC_CFG_WMASK 32'h003F_3000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TXC_TABLE_SEL_BIT 21
`define TXC_FFB_BIT 20
`define TXC_ALLOC_HI 19
`define TXC_ALLOC_LO 16
`define TXC_LEVEL_HI 13
`define TXC_LEVEL_LO 12

// ----------------------------------------------------------------------------
// Memory split, in bytes
// ----------------------------------------------------------------------------
`define TXC_TOTAL_BYTES 15'h4000
`define TXC_TX_STATUS_BYTES 15'h0200
`define TXC_TX_DATA_RESET 15'h1200
`define TXC_RX_RESET 15'h2C00

// ----------------------------------------------------------------------------
// Start thresholds in words; plain defaults, table not given
// ----------------------------------------------------------------------------
`define TXC_THR10_0 6'h04
`define TXC_THR10_1 6'h08
`define TXC_THR10_2 6'h10
`define TXC_THR10_3 6'h18
`define TXC_THR100_0 6'h08
`define TXC_THR100_1 6'h10
`define TXC_THR100_2 6'h18
`define TXC_THR100_3 6'h20

// ----------------------------------------------------------------------------
// Buffer shape
// ----------------------------------------------------------------------------
`define TXC_FIFO_DEPTH 32
`define TXC_FIFO_WIDTH 34

`endif

// file: include/txc_pkg.sv
// Types for the transmit start and FIFO allocation configuration block
package txc_pkg;
  typedef enum logic [1:0] {
    TXC_IDLE,
    TXC_SEND,
    TXC_DROP
  } txc_state_t;
endpackage : txc_pkg

// file: testbench/tb_top.sv
// Testbench for the transmit start and FIFO allocation block
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, wr, rd, tv, tc, tl, trdy, mrdy, mv, mc, ml, und, sink_en;
  logic [7:0] addr;
  logic [31:0] wd, rdat, td, md, lw, v;
  logic [14:0] txb, rxb;
  int words, cmds, w0, und_cnt, mismatches, n_compared;

  txc_top dut (.ref_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat), .tx_valid_in(tv),
    .tx_data_in(td), .tx_cmd_in(tc), .tx_last_in(tl), .tx_ready_out(trdy),
    .mac_ready_in(mrdy), .mac_valid_out(mv), .mac_data_out(md), .mac_cmd_out(mc),
    .mac_last_out(ml), .tx_underrun_out(und), .tx_data_bytes_out(txb), .rx_bytes_out(rxb));
  txc_line_model sink (.ref_clk_in(clk), .reset_n_in(rst_n), .enable_in(sink_en),
    .mac_valid_in(mv), .mac_data_in(md), .mac_cmd_in(mc), .mac_last_in(ml),
    .mac_ready_out(mrdy), .words_out(words), .cmds_out(cmds), .last_word_out(lw));

  // ---------------------------------------------------------------------------
  // Clock, watchdog, monitors
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  always @(negedge clk) if (und === 1'b1) und_cnt++;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk) addr = a; wd = d; wr = 1'b1;
    @(negedge clk) wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wreg
  task chkreg(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk) addr = a; rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    @(negedge clk) chk(name, exp, rdat);
  endtask : chkreg
  task chksize(input logic [14:0] etx, input logic [14:0] erx);
    chk("tx bytes", {17'h0_0000, etx}, {17'h0_0000, txb});
    chk("rx bytes", {17'h0_0000, erx}, {17'h0_0000, rxb});
  endtask : chksize
  // Words base+from .. base+to-1; command flag on word 0 of the frame
  task frame(input logic [31:0] base, input int from, input int to, input logic last);
    for (int i = from; i < to; i++) begin
      tv = 1'b1; td = base + i; tc = (i == 0); tl = last && (i == to - 1);
      while (trdy !== 1'b1) @(negedge clk);
      @(negedge clk);
    end
    tv = 1'b0;
  endtask : frame
  task got(input string name, input int n);
    repeat (20) @(negedge clk);
    chk(name, n, words - w0);
  endtask : got
  task give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, tv, tc, tl, addr, wd, td, und_cnt} = '0;
    sink_en = 1'b1;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chkreg("cfg reset", 8'h74, 32'h0005_0000);
    chksize(15'h1200, 15'h2C00);
    $display("test reset values done");
    wreg(8'h74, 32'hFFFF_FFFF);
    chkreg("cfg mask", 8'h74, 32'h003F_3000);
    wreg(8'h74, 32'h0002_0000); // Smallest legal allocation
    chksize(15'h0600, 15'h3800);
    wreg(8'h74, 32'h000E_0000);
    chksize(15'h3600, 15'h0800);
    wreg(8'h70, 32'hFFFF_FFFF);
    chkreg("unmapped", 8'h70, 32'h0000_0000);
    chkreg("cfg kept", 8'h74, 32'h000E_0000);
    $display("test register access done");
    // Full frame buffering with a low threshold selected that must not apply
    wreg(8'h74, 32'h0035_0000);
    w0 = words;
    frame(32'hA000_0000, 0, 5, 1'b0);
    got("held frame", 0);
    frame(32'hA000_0000, 5, 6, 1'b1);
    got("whole frame", 6);
    chk("cmd words", 1, cmds);
    chk("last word", 32'hA000_0005, lw);
    chk("last flag", 32'h0000_0001, {31'h0000_0000, ml});
    $display("test full frame done");
    // Mode one for 10M, level 0, host then starves the line
    wreg(8'h74, 32'h0025_0000);
    w0 = words;
    und_cnt = 0;
    frame(32'hB000_0000, 0, 4, 1'b0);
    got("early start", 4);
    chk("underrun", 1, {31'h0000_0000, und_cnt != 0});
    frame(32'hB000_0000, 4, 8, 1'b1);
    got("flushed rest", 4);
    $display("test threshold and underrun done");
    // Mode zero for 100M selects the higher table
    wreg(8'h74, 32'h0005_0000);
    w0 = words;
    frame(32'hC000_0000, 0, 5, 1'b0);
    got("below threshold", 0);
    frame(32'hC000_0000, 5, 8, 1'b1);
    got("after threshold", 8);
    chk("last word", 32'hC000_0007, lw);
    // Mode one, level two: start only once sixteen words are in
    wreg(8'h74, 32'h0025_2000);
    w0 = words;
    und_cnt = 0;
    frame(32'hE000_0000, 0, 15, 1'b0);
    got("level two held", 0);
    frame(32'hE000_0000, 15, 16, 1'b0);
    got("level two start", 16);
    chk("underrun two", 1, {31'h0000_0000, und_cnt != 0});
    frame(32'hE000_0000, 16, 18, 1'b1);
    got("level two flushed", 16);
    $display("test table select done");
    // Fill the buffer against a stalled line, then drain it
    sink_en = 1'b0;
    w0 = words;
    frame(32'hD000_0000, 0, 32, 1'b1);
    chk("ready full", 32'h0000_0000, {31'h0000_0000, trdy});
    sink_en = 1'b1;
    repeat (60) @(negedge clk);
    chk("drained", 32, words - w0);
    chk("ready empty", 32'h0000_0001, {31'h0000_0000, trdy});
    $display("test fill and drain done");
    give_verdict();
  end
endmodule : tb_top

// file: testbench/txc_line_model.sv
// Line side model: asks for words and records what the block hands over
`timescale 1ns/1ps
module txc_line_model (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic mac_valid_in,
  input wire logic [31:0] mac_data_in,
  input wire logic mac_cmd_in,
  input wire logic mac_last_in,
  output logic mac_ready_out,
  output int words_out,
  output int cmds_out,
  output logic [31:0] last_word_out
);
  // ---------------------------------------------------------------------------
  // Demand and capture
  // ---------------------------------------------------------------------------
  // Line demands a word every cycle while enabled; stalls model a busy line
  always @(negedge ref_clk_in) begin
    mac_ready_out <= enable_in & reset_n_in;
    if (!reset_n_in) begin
      words_out <= 0;
      cmds_out <= 0;
      last_word_out <= 32'h0000_0000;
    end else if (mac_valid_in === 1'b1) begin
      words_out <= words_out + 1;
      if (mac_cmd_in === 1'b1) cmds_out <= cmds_out + 1;
      last_word_out <= mac_data_in;
    end
  end
endmodule : txc_line_model
